// >>> hdl/mfid_pkg.sv
// Purpose: Constants for the memory-model and instruction-set id bank
// Assumes: Access arrives as a decoded coprocessor-15 system register op
// Notes: All field values are fixed; no reset values are needed
`default_nettype none
package mfid_pkg;

	// ****************************************************************
	// Access encoding
	// ****************************************************************
	localparam logic [3:0] COPROC_SYS = 4'hf;
	localparam logic [2:0] OPC1_ID = 3'h0;
	localparam logic [3:0] CRN_ID = 4'h0;
	localparam logic [3:0] CRM_MMFR = 4'h1;
	localparam logic [3:0] CRM_ISAR = 4'h2;
	localparam logic [2:0] OPC2_MMF_TWO = 3'h6;
	localparam logic [2:0] OPC2_MMF_THREE = 3'h7;
	localparam logic [2:0] OPC2_ISA_ZERO = 3'h0;

	// ****************************************************************
	// Privilege levels
	// ****************************************************************
	localparam logic [1:0] PL_USER = 2'h0;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int FIELD_W = 4;
	localparam int FIELD_N = 8;
	localparam int REG_W = FIELD_W * FIELD_N;

	// ****************************************************************
	// Field values, index 7 is bits 31:28
	// ****************************************************************
	localparam logic [3:0] MF2_HW_ACCESS_FLAG = 4'h0;
	localparam logic [3:0] MF2_WAIT_STALL = 4'h1;
	localparam logic [3:0] MF2_BARRIER = 4'h2;
	localparam logic [3:0] MF2_UNIFIED_TB = 4'h6;
	localparam logic [3:0] MF2_SPLIT_TB = 4'h0;
	localparam logic [3:0] MF2_CACHE_RANGE = 4'h0;
	localparam logic [3:0] MF2_BG_PREFETCH = 4'h0;
	localparam logic [3:0] MF2_FG_PREFETCH = 4'h0;

	localparam logic [3:0] MF3_SUPERSECTION = 4'h0;
	localparam logic [3:0] MF3_CACHED_SIZE = 4'h2;
	localparam logic [3:0] MF3_COHERENT_WALK = 4'h1;
	localparam logic [3:0] MF3_RESERVED = 4'h0;
	localparam logic [3:0] MF3_BROADCAST = 4'h2;
	localparam logic [3:0] MF3_PREDICTOR = 4'h2;
	localparam logic [3:0] MF3_SETWAY = 4'h1;
	localparam logic [3:0] MF3_BY_ADDRESS = 4'h1;

	localparam logic [3:0] IS0_RESERVED = 4'h0;
	localparam logic [3:0] IS0_DIVIDE = 4'h2;
	localparam logic [3:0] IS0_BREAKPOINT = 4'h1;
	localparam logic [3:0] IS0_COPROC = 4'h0;
	localparam logic [3:0] IS0_CMP_BRANCH = 4'h1;
	localparam logic [3:0] IS0_BITFIELD = 4'h1;
	localparam logic [3:0] IS0_LZ_COUNT = 4'h1;
	localparam logic [3:0] IS0_SWAP = 4'h0;

	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ****************************************************************
	// Maintenance operation kinds
	// ****************************************************************
	typedef enum logic [1:0] {
		MFID_OP_INVAL = 2'h0,
		MFID_OP_CLEAN = 2'h1,
		MFID_OP_CLEAN_INVAL = 2'h2
	} mfid_dc_op_t;

endpackage
`default_nettype wire

// >>> hdl/mfid_field_pack.sv
// Purpose: Packs eight 4-bit feature fields into one 32-bit word
// Assumes: f7 lands in bits 31:28, f0 in bits 3:0
// Notes: Purely combinational
`timescale 1ns/10ps
`default_nettype none
module mfid_field_pack (
	input wire logic [3:0] f7,
	input wire logic [3:0] f6,
	input wire logic [3:0] f5,
	input wire logic [3:0] f4,
	input wire logic [3:0] f3,
	input wire logic [3:0] f2,
	input wire logic [3:0] f1,
	input wire logic [3:0] f0,
	output logic [31:0] word
);
	always_comb begin
		word = {f7, f6, f5, f4, f3, f2, f1, f0};
	end
endmodule
`default_nettype wire

// >>> hdl/mfid_regs.sv
// Purpose: Read-only memory-model and instruction-set id registers
// Assumes: Core presents one decoded system register op per valid pulse
// Notes: Answer arrives one clock after a request that hits one of the three id registers; misses get none; no stall
`timescale 1ns/10ps
`default_nettype none
module mfid_regs (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [3:0] req_coproc,
	input wire logic [2:0] req_opc1,
	input wire logic [3:0] req_crn,
	input wire logic [3:0] req_crm,
	input wire logic [2:0] req_opc2,
	input wire logic [1:0] req_priv,
	input wire logic secure_config_nonsecure_bit,
	input wire logic dc_op_valid,
	input wire logic [1:0] dc_op_kind,
	input wire logic dc_op_broadcast,
	output logic rsp_valid,
	output logic [31:0] rsp_data,
	output logic rsp_undef,
	output logic local_op_valid,
	output logic [1:0] local_op_kind,
	output logic bcast_op_valid,
	output logic [1:0] bcast_op_kind
);

	// ****************************************************************
	// Constant register images
	// ****************************************************************
	logic [31:0] memory_model_feature_two;
	logic [31:0] memory_model_feature_three;
	logic [31:0] instruction_set_attribute_zero;

	// ****************************************************************
	// Memory model two fields
	// ****************************************************************
	logic [3:0] hardware_access_flag_field;
	logic [3:0] wait_interrupt_stall_field;
	logic [3:0] barrier_ops_field;
	logic [3:0] unified_translation_buffer_field;
	logic [3:0] split_translation_buffer_field;
	logic [3:0] split_cache_range_field;
	logic [3:0] split_cache_background_prefetch_field;
	logic [3:0] split_cache_foreground_prefetch_field;

	always_comb begin
		hardware_access_flag_field = mfid_pkg::MF2_HW_ACCESS_FLAG;
		wait_interrupt_stall_field = mfid_pkg::MF2_WAIT_STALL;
		barrier_ops_field = mfid_pkg::MF2_BARRIER;
		unified_translation_buffer_field = mfid_pkg::MF2_UNIFIED_TB;
		split_translation_buffer_field = mfid_pkg::MF2_SPLIT_TB;
		split_cache_range_field = mfid_pkg::MF2_CACHE_RANGE;
		split_cache_background_prefetch_field = mfid_pkg::MF2_BG_PREFETCH;
		split_cache_foreground_prefetch_field = mfid_pkg::MF2_FG_PREFETCH;
	end

	mfid_field_pack u_mf2 (
		.f7(hardware_access_flag_field),
		.f6(wait_interrupt_stall_field),
		.f5(barrier_ops_field),
		.f4(unified_translation_buffer_field),
		.f3(split_translation_buffer_field),
		.f2(split_cache_range_field),
		.f1(split_cache_background_prefetch_field),
		.f0(split_cache_foreground_prefetch_field),
		.word(memory_model_feature_two)
	);

	// ****************************************************************
	// Memory model three fields
	// ****************************************************************
	logic [3:0] supersection_field;
	logic [3:0] cached_memory_size_field;
	logic [3:0] coherent_table_walk_field;
	logic [3:0] model_three_reserved_field;
	logic [3:0] maintenance_broadcast_field;
	logic [3:0] predictor_maintenance_field;
	logic [3:0] cache_setway_maintenance_field;
	logic [3:0] cache_address_maintenance_field;

	// Zero here still means supersections are present
	always_comb begin
		supersection_field = mfid_pkg::MF3_SUPERSECTION;
		cached_memory_size_field = mfid_pkg::MF3_CACHED_SIZE;
		coherent_table_walk_field = mfid_pkg::MF3_COHERENT_WALK;
		model_three_reserved_field = mfid_pkg::MF3_RESERVED;
		maintenance_broadcast_field = mfid_pkg::MF3_BROADCAST;
		predictor_maintenance_field = mfid_pkg::MF3_PREDICTOR;
		cache_setway_maintenance_field = mfid_pkg::MF3_SETWAY;
		cache_address_maintenance_field = mfid_pkg::MF3_BY_ADDRESS;
	end

	mfid_field_pack u_mf3 (
		.f7(supersection_field),
		.f6(cached_memory_size_field),
		.f5(coherent_table_walk_field),
		.f4(model_three_reserved_field),
		.f3(maintenance_broadcast_field),
		.f2(predictor_maintenance_field),
		.f1(cache_setway_maintenance_field),
		.f0(cache_address_maintenance_field),
		.word(memory_model_feature_three)
	);

	// ****************************************************************
	// Instruction set zero fields
	// ****************************************************************
	logic [3:0] set_zero_reserved_field;
	logic [3:0] divide_insn_field;
	logic [3:0] breakpoint_insn_field;
	logic [3:0] coprocessor_insn_field;
	logic [3:0] compare_and_branch_field;
	logic [3:0] bitfield_insn_field;
	logic [3:0] leading_zero_count_field;
	logic [3:0] swap_insn_field;

	always_comb begin
		set_zero_reserved_field = mfid_pkg::IS0_RESERVED;
		divide_insn_field = mfid_pkg::IS0_DIVIDE;
		breakpoint_insn_field = mfid_pkg::IS0_BREAKPOINT;
		coprocessor_insn_field = mfid_pkg::IS0_COPROC;
		compare_and_branch_field = mfid_pkg::IS0_CMP_BRANCH;
		bitfield_insn_field = mfid_pkg::IS0_BITFIELD;
		leading_zero_count_field = mfid_pkg::IS0_LZ_COUNT;
		swap_insn_field = mfid_pkg::IS0_SWAP;
	end

	mfid_field_pack u_is0 (
		.f7(set_zero_reserved_field),
		.f6(divide_insn_field),
		.f5(breakpoint_insn_field),
		.f4(coprocessor_insn_field),
		.f3(compare_and_branch_field),
		.f2(bitfield_insn_field),
		.f1(leading_zero_count_field),
		.f0(swap_insn_field),
		.word(instruction_set_attribute_zero)
	);

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic id_space;
	logic hit_mf2;
	logic hit_mf3;
	logic hit_is0;
	logic hit_any;

	always_comb begin
		id_space = (req_coproc == mfid_pkg::COPROC_SYS) &&
			(req_opc1 == mfid_pkg::OPC1_ID) &&
			(req_crn == mfid_pkg::CRN_ID);
		hit_mf2 = id_space && (req_crm == mfid_pkg::CRM_MMFR) &&
			(req_opc2 == mfid_pkg::OPC2_MMF_TWO);
		hit_mf3 = id_space && (req_crm == mfid_pkg::CRM_MMFR) &&
			(req_opc2 == mfid_pkg::OPC2_MMF_THREE);
		hit_is0 = id_space && (req_crm == mfid_pkg::CRM_ISAR) &&
			(req_opc2 == mfid_pkg::OPC2_ISA_ZERO);
		hit_any = hit_mf2 || hit_mf3 || hit_is0;
	end

	// ****************************************************************
	// Access check
	// ****************************************************************
	logic priv_ok;
	logic refused;
	logic [31:0] read_word;

	// Level 0 is shut out for reads too, not only for writes
	always_comb begin
		priv_ok = (req_priv != mfid_pkg::PL_USER);
		refused = req_write || !priv_ok;
		case ({hit_mf2, hit_mf3, hit_is0})
			3'h4: read_word = memory_model_feature_two;
			3'h2: read_word = memory_model_feature_three;
			3'h1: read_word = instruction_set_attribute_zero;
			default: read_word = mfid_pkg::READ_ZERO;
		endcase
	end

	// ****************************************************************
	// Answer path
	// ****************************************************************
	logic next_rsp_valid;
	logic [31:0] next_rsp_data;
	logic next_rsp_undef;

	// Security state is deliberately not looked at: one shared copy
	always_comb begin
		next_rsp_valid = req_valid && hit_any;
		next_rsp_undef = 1'b0;
		next_rsp_data = mfid_pkg::READ_ZERO;
		if (req_valid && hit_any) begin
			if (refused) begin
				next_rsp_undef = 1'b1;
			end else begin
				next_rsp_data = read_word;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_valid <= 1'b0;
			rsp_data <= mfid_pkg::READ_ZERO;
			rsp_undef <= 1'b0;
		end else begin
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			rsp_undef <= next_rsp_undef;
		end
	end

	// ****************************************************************
	// Data-cache maintenance translation
	// ****************************************************************
	logic next_local_valid;
	logic [1:0] next_local_kind;
	logic next_bcast_valid;
	logic [1:0] next_bcast_kind;

	// Local invalidate is widened to clean-and-invalidate so no dirty data is lost
	always_comb begin
		next_local_valid = dc_op_valid;
		next_local_kind = dc_op_kind;
		if (dc_op_kind == mfid_pkg::MFID_OP_INVAL) begin
			next_local_kind = mfid_pkg::MFID_OP_CLEAN_INVAL;
		end
		next_bcast_valid = dc_op_valid && dc_op_broadcast;
		next_bcast_kind = dc_op_kind;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			local_op_valid <= 1'b0;
			local_op_kind <= mfid_pkg::MFID_OP_INVAL;
			bcast_op_valid <= 1'b0;
			bcast_op_kind <= mfid_pkg::MFID_OP_INVAL;
		end else begin
			local_op_valid <= next_local_valid;
			local_op_kind <= next_local_kind;
			bcast_op_valid <= next_bcast_valid;
			bcast_op_kind <= next_bcast_kind;
		end
	end

endmodule
`default_nettype wire

// >>> tb/mfid_regs_asserts.sv
// Purpose: Port checks for the id register bank
// Assumes: One clock from a taken request to its answer
// Notes: Bound to the bank from the bench top
`timescale 1ns/10ps
`default_nettype none
module mfid_regs_asserts (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [3:0] req_coproc,
	input wire logic [2:0] req_opc1,
	input wire logic [3:0] req_crn,
	input wire logic [3:0] req_crm,
	input wire logic [2:0] req_opc2,
	input wire logic [1:0] req_priv,
	input wire logic dc_op_valid,
	input wire logic [1:0] dc_op_kind,
	input wire logic dc_op_broadcast,
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_data,
	input wire logic rsp_undef,
	input wire logic local_op_valid,
	input wire logic [1:0] local_op_kind,
	input wire logic bcast_op_valid,
	input wire logic [1:0] bcast_op_kind
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	wire logic hit;
	assign hit = req_valid && req_coproc == 4'hf && req_opc1 == 3'h0
		&& req_crn == 4'h0 && ((req_crm == 4'h1 && req_opc2[2:1] == 2'h3)
		|| (req_crm == 4'h2 && req_opc2 == 3'h0));
	sequence rd(m, o);
		hit && !req_write && req_priv != 2'h0 && req_crm == m && req_opc2 == o;
	endsequence
	sequence ok(d);
		rsp_valid && !rsp_undef && rsp_data == d;
	endsequence
	answer_follows_a: assert property (hit |=> rsp_valid)
		else $error("request not answered");
	quiet_on_miss_a: assert property (!hit |=> !rsp_valid)
		else $error("answer without request");
	mf_two_value_a: assert property (
		rd(4'h1, 3'h6) |=> ok(32'h0126_0000))
		else $error("model two word wrong");
	mf_three_value_a: assert property (
		rd(4'h1, 3'h7) |=> ok(32'h0210_2211))
		else $error("model three word wrong");
	set_zero_value_a: assert property (
		rd(4'h2, 3'h0) |=> ok(32'h0210_1110))
		else $error("set zero word wrong");
	refuse_undef_a: assert property (hit && (req_write || req_priv == 2'h0)
		|=> rsp_valid && rsp_undef && rsp_data == 32'h0)
		else $error("refused access not undefined");
	local_clean_a: assert property (dc_op_valid && dc_op_kind == 2'h0
		|=> local_op_valid && local_op_kind == 2'h2)
		else $error("local invalidate not widened");
	bcast_plain_a: assert property (dc_op_valid && dc_op_broadcast
		|=> bcast_op_valid && bcast_op_kind == $past(dc_op_kind))
		else $error("broadcast kind changed");
endmodule
`default_nettype wire

// >>> tb/mfid_regs_tb_top.sv
// Purpose: Self-checking bench for the id register bank
// Assumes: Answers come one clock after a taken request
// Notes: Inputs change on the falling edge only
`timescale 1ns/10ps
`default_nettype none
module mfid_regs_tb_top;
	logic sys_clk, reset_n, req_valid, req_write, secure_config_nonsecure_bit;
	logic [3:0] req_coproc, req_crn, req_crm;
	logic [2:0] req_opc1, req_opc2;
	logic [1:0] req_priv, dc_op_kind, local_op_kind, bcast_op_kind;
	logic dc_op_valid, dc_op_broadcast, rsp_valid, rsp_undef;
	logic local_op_valid, bcast_op_valid;
	logic [31:0] rsp_data;
	int errors = 0;
	int checks_done = 0;
	logic [3:0] cm[3] = '{4'h1, 4'h1, 4'h2};
	logic [2:0] op[3] = '{3'h6, 3'h7, 3'h0};
	logic [31:0] ex[3] = '{32'h0126_0000, 32'h0210_2211, 32'h0210_1110};
	mfid_regs mfid_regs_inst (.sys_clk, .reset_n, .req_valid, .req_write,
		.req_coproc, .req_opc1, .req_crn, .req_crm, .req_opc2, .req_priv,
		.secure_config_nonsecure_bit, .dc_op_valid, .dc_op_kind,
		.dc_op_broadcast, .rsp_valid, .rsp_data, .rsp_undef, .local_op_valid,
		.local_op_kind, .bcast_op_valid, .bcast_op_kind);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [3:0] c, input logic [2:0] o,
		input logic [1:0] p, input logic w, input logic v, input logic u,
		input logic [31:0] d);
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_write = w;
		req_crm = c;
		req_opc2 = o;
		req_priv = p;
		@(negedge sys_clk);
		req_valid = 1'b0;
		chk({rsp_valid, rsp_undef, rsp_data}, {v, u, d});
	endtask
	task automatic t_reads;
		for (int i = 0; i < 3; i++)
			for (int p = 1; p < 4; p++)
				for (int s = 0; s < 2; s++) begin
					secure_config_nonsecure_bit = s[0];
					acc(cm[i], op[i], p[1:0], 1'b0, 1'b1, 1'b0, ex[i]);
				end
		$display("reads done");
	endtask
	task automatic t_refuse;
		for (int i = 0; i < 3; i++) begin
			acc(cm[i], op[i], 2'h1, 1'b1, 1'b1, 1'b1, 32'h0);
			acc(cm[i], op[i], 2'h0, 1'b0, 1'b1, 1'b1, 32'h0);
		end
		acc(4'h1, 3'h5, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0);
		req_coproc = 4'he;
		acc(4'h2, 3'h0, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0);
		req_coproc = 4'hf;
		$display("refusals done");
	endtask
	task automatic t_maint;
		for (int k = 0; k < 3; k++)
			for (int b = 0; b < 2; b++) begin
				@(negedge sys_clk);
				dc_op_valid = 1'b1;
				dc_op_kind = k[1:0];
				dc_op_broadcast = b[0];
				@(negedge sys_clk);
				dc_op_valid = 1'b0;
				chk({28'h0, local_op_valid, local_op_kind, bcast_op_valid,
					bcast_op_kind & {2{b[0]}}}, {28'h0, 1'b1,
					(k == 0) ? 2'h2 : k[1:0], b[0], k[1:0] & {2{b[0]}}});
			end
		$display("maintenance done");
	endtask
	task automatic t_reset;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_crm = 4'h1;
		req_opc2 = 3'h7;
		req_priv = 2'h2;
		dc_op_valid = 1'b1;
		dc_op_broadcast = 1'b1;
		@(negedge sys_clk);
		{req_valid, dc_op_valid, reset_n} = 3'h0;
		#1;
		chk({rsp_valid, rsp_undef, rsp_data}, 34'h0);
		chk({28'h0, local_op_valid, local_op_kind, bcast_op_valid,
			bcast_op_kind}, 34'h0);
		@(negedge sys_clk);
		reset_n = 1'b1;
		acc(4'h1, 3'h7, 2'h2, 1'b0, 1'b1, 1'b0, ex[1]);
		$display("reset done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		{reset_n, req_valid, req_write, secure_config_nonsecure_bit} = 4'h0;
		{req_crn, req_crm, req_opc1, req_opc2, req_priv} = 16'h0;
		req_coproc = 4'hf;
		{dc_op_valid, dc_op_kind, dc_op_broadcast} = 4'h0;
		repeat (16) @(negedge sys_clk);
		reset_n = 1'b1;
		t_reads();
		t_refuse();
		t_maint();
		t_reset();
		print_verdict();
	end
endmodule
bind mfid_regs mfid_regs_asserts mfid_regs_asserts_inst (.sys_clk, .reset_n,
	.req_valid, .req_write, .req_coproc, .req_opc1, .req_crn, .req_crm,
	.req_opc2, .req_priv, .dc_op_valid, .dc_op_kind, .dc_op_broadcast,
	.rsp_valid, .rsp_data, .rsp_undef, .local_op_valid, .local_op_kind,
	.bcast_op_valid, .bcast_op_kind);
`default_nettype wire
